// ---- core/afe_pkg.sv ----
// Constants and types shared by the accelerometer front end
package afe_pkg;
   // Clock rates and derived per-microsecond slot arithmetic
   localparam int CLK_HZ = 25_000_000;
   localparam int MOD_HZ = 1_000_000;
   localparam int DSP_HZ = 8_000_000;
   localparam logic [5:0] PHASE_MOD = 6'(CLK_HZ / MOD_HZ);
   localparam logic [5:0] DSP_STEP = 6'(DSP_HZ / MOD_HZ);
   localparam logic [1:0] QUIET_SLOT = 2'h3;

   // Widths
   localparam int PRESCALE_W = 10;
   localparam int COUNT_W = 8;
   localparam int CORE_DIV_W = 8;
   localparam int CRC_W = 8;
   localparam int SINC_W = 14;
   localparam int AX_CFG_W = 5;
   localparam int DEFL_W = 8;
   localparam int ST_W = 3;

   // Decimation phase ends
   localparam logic [3:0] DEC8_LAST = 4'h7;
   localparam logic [3:0] DEC16_LAST = 4'hF;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_GCFG = 8'h04;
   localparam logic [7:0] OFF_AXCFG [2] = '{8'h08, 8'h0C};
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_COUNT = 8'h14;
   localparam logic [7:0] OFF_DEFL [2] = '{8'h18, 8'h1C};
   localparam logic [7:0] OFF_DATA [2] = '{8'h20, 8'h24};

   // Field positions
   localparam int KEY_LO_BIT = 0;
   localparam int KEY_HI_BIT = 1;
   localparam int LOCK_BIT = 0;
   localparam int LPF_DEC16_BIT = 3;
   localparam int AX_ST_BIT = 4;
   localparam int ST_RST_BIT = 0;
   localparam int ST_CRC_BIT = 1;
   localparam int ST_FAULT_BIT = 2;

   // Reset values
   localparam logic RST_FLAG_RST = 1'b1;
   localparam logic LOCK_RST = 1'b0;
   localparam logic [AX_CFG_W-1:0] AX_CFG_RST = 5'h00;
   localparam logic [DEFL_W-1:0] DEFL_RST = 8'h00;
   localparam logic [COUNT_W-1:0] COUNT_RST = 8'h00;
   localparam logic [CRC_W-1:0] CRC_SEED = 8'hFF;
   localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;

   // Soft reset key sequence
   localparam logic [1:0] KEY_STEP0 = 2'h3;
   localparam logic [1:0] KEY_STEP1 = 2'h1;
   localparam logic [1:0] KEY_STEP2 = 2'h2;

   typedef enum logic [1:0] {AFE_KEY_IDLE, AFE_KEY_ONE, AFE_KEY_TWO} afe_key_t;
endpackage : afe_pkg

// ---- core/afe_clkgen.sv ----
// DSP slot strobes and modulator clock generation
`timescale 1ns/10ps
module afe_clkgen
   import afe_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   output logic tick_o,
   output logic gated_o,
   output logic mod_clk_o,
   output logic mod_rise_o
);
   logic [5:0] acc_ff;
   logic [5:0] nxt_acc;
   logic wrap;
   logic [2:0] slot_ff;
   logic [2:0] nxt_slot;

   assign nxt_acc = acc_ff + DSP_STEP;
   assign wrap = nxt_acc >= PHASE_MOD;
   assign nxt_slot = slot_ff + 3'h1;

   // Eight slots per microsecond
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         acc_ff <= 6'h00;
      end else begin
         acc_ff <= wrap ? nxt_acc - PHASE_MOD : nxt_acc;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         slot_ff <= 3'h0;
      end else if (wrap) begin
         slot_ff <= nxt_slot;
      end
   end

   // Slot before each modulator edge is dropped, six of eight remain
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
         gated_o <= 1'b0;
         mod_clk_o <= 1'b0;
         mod_rise_o <= 1'b0;
      end else begin
         tick_o <= wrap;
         gated_o <= wrap & (nxt_slot[1:0] != QUIET_SLOT);
         if (wrap) begin
            mod_clk_o <= nxt_slot[2];
         end
         mod_rise_o <= wrap & slot_ff[2] & (slot_ff[1:0] == QUIET_SLOT);
      end
   end
endmodule : afe_clkgen

// ---- core/afe_sinc.sv ----
// Third order sinc decimator, decimation 8 or 16
`timescale 1ns/10ps
module afe_sinc
   import afe_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic bit_en_i,
   input wire logic bit_i,
   input wire logic dec16_i,
   output logic [SINC_W-1:0] data_o,
   output logic valid_o
);
   logic [SINC_W-1:0] int_ff [3];
   logic [SINC_W-1:0] nxt_int [3];
   logic [SINC_W-1:0] stage [4];
   logic [SINC_W-1:0] z1_ff [3];
   logic [SINC_W-1:0] z2_ff [3];
   logic [3:0] phase_ff;
   logic last_phase;
   logic dump;

   always_comb begin
      nxt_int[0] = int_ff[0] + {{(SINC_W-1){1'b0}}, bit_i};
      nxt_int[1] = int_ff[1] + nxt_int[0];
      nxt_int[2] = int_ff[2] + nxt_int[1];
   end

   assign last_phase = phase_ff == (dec16_i ? DEC16_LAST : DEC8_LAST);
   assign dump = bit_en_i & last_phase;
   assign stage[0] = nxt_int[2];

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         int_ff <= '{3{{SINC_W{1'b0}}}};
      end else if (bit_en_i) begin
         int_ff <= nxt_int;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         phase_ff <= 4'h0;
      end else if (bit_en_i) begin
         phase_ff <= last_phase ? 4'h0 : phase_ff + 4'h1;
      end
   end

   // Comb delay spans sixteen input bits at either decimation
   for (genvar k = 0; k < 3; k++) begin : g_comb
      assign stage[k+1] = stage[k] - (dec16_i ? z1_ff[k] : z2_ff[k]);
      always_ff @(posedge mclk_i) begin
         if (rst_i) begin
            z1_ff[k] <= {SINC_W{1'b0}};
            z2_ff[k] <= {SINC_W{1'b0}};
         end else if (dump) begin
            z1_ff[k] <= stage[k];
            z2_ff[k] <= z1_ff[k];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         data_o <= {SINC_W{1'b0}};
         valid_o <= 1'b0;
      end else begin
         valid_o <= dump;
         if (dump) begin
            data_o <= stage[3];
         end
      end
   end
endmodule : afe_sinc

// ---- core/afe_front_end.sv ----
// Accelerometer digital front end with APB register slave
// Summary of operation
// - Sample each axis modulator bit once per microsecond.
// - Decimate with third order sixteen-tap sinc, by 8 or 16.
// - Run DSP slots at 8 MHz, six effective per microsecond.
// - Drop the one DSP slot just before every modulator edge.
// - Free running 8-bit counter behind a 10-bit prescaler.
// - Counter steps every 128 us and wraps every 32.768 ms.
// - Per-axis core clocks from base down to base over 256.
// - Clock CRC of both axis cores updated every base cycle.
// - Self test suspends offset cancellation, deflection code is only stored and read back.
// - Axis config writes ignored once the init lock is set.
// - Production self-test deflection kept per axis as 8-bit code.
// - Analog regulator failure sets reset flag and fault response.
// - Ground loss or digital regulator failure forces device reset.
// - Three keyed control writes trigger a full device reset.
// - Per-axis 1-bit low-pass select (config bit 3) sets the decimation factor.
// - Reading status clears the reset-occurred flag.
`timescale 1ns/10ps
module afe_front_end
   import afe_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic sd_x_i,
   input wire logic sd_y_i,
   input wire logic vreg_uv_i,
   input wire logic vreg_ov_i,
   input wire logic vrega_uv_i,
   input wire logic vrega_ov_i,
   input wire logic vss_loss_i,
   input wire logic vssa_loss_i,
   output logic mod_clk_o,
   output logic dsp_clk_en_o,
   output logic [SINC_W-1:0] x_data_o,
   output logic x_valid_o,
   output logic [SINC_W-1:0] y_data_o,
   output logic y_valid_o,
   output logic selftest_x_o,
   output logic selftest_y_o,
   output logic offset_hold_o,
   output logic fault_resp_o
);
   logic hard_fail;
   logic ana_fail;
   logic int_rst;
   logic soft_rst_ff;
   afe_key_t key_ff;
   logic lock_ff;
   logic [AX_CFG_W-1:0] cfg_ff [2];
   logic [DEFL_W-1:0] defl_ff [2];
   logic [CORE_DIV_W-1:0] div_ff [2];
   logic [CRC_W-1:0] crc_ff [2];
   logic [SINC_W-1:0] sinc_data [2];
   logic sinc_valid [2];
   logic [1:0] sd_bits;
   logic [1:0] st_ff;
   logic rst_flag_ff;
   logic crc_err_ff;
   logic fault_ff;
   logic [PRESCALE_W-1:0] prescale_ff;
   logic [COUNT_W-1:0] count_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] rd_mux;
   logic setup;
   logic wr_en;
   logic st_rd;
   logic wr_ctrl;
   logic [1:0] key;
   logic tick;
   logic gated;
   logic mod_rise;

   // Rolling CRC step, one byte folded in per call
   function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] crc,
                                                 input logic [CORE_DIV_W-1:0] dat);
      logic [CRC_W-1:0] c;
      c = crc ^ dat;
      for (int i = 0; i < CRC_W; i++) begin
         c = c[CRC_W-1] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc_step

   function automatic logic is_mapped(input logic [7:0] a);
      return (a == OFF_CTRL) || (a == OFF_GCFG) || (a == OFF_AXCFG[0]) ||
             (a == OFF_AXCFG[1]) || (a == OFF_STATUS) || (a == OFF_COUNT) ||
             (a == OFF_DEFL[0]) || (a == OFF_DEFL[1]) || (a == OFF_DATA[0]) ||
             (a == OFF_DATA[1]);
   endfunction : is_mapped

   // Reset sources
   assign hard_fail = vreg_uv_i | vreg_ov_i | vss_loss_i | vssa_loss_i;
   assign ana_fail = vrega_uv_i | vrega_ov_i;
   assign int_rst = sys_rst_i | soft_rst_ff | hard_fail;

   // APB handshake: answer in the first access cycle
   assign setup = psel_i & ~penable_i;
   assign wr_en = psel_i & penable_i & pready_ff & pwrite_i;
   assign st_rd = psel_i & penable_i & pready_ff & ~pwrite_i & (paddr_i == OFF_STATUS);
   assign wr_ctrl = wr_en & (paddr_i == OFF_CTRL);
   assign key = pwdata_i[KEY_HI_BIT:KEY_LO_BIT];

   always_ff @(posedge mclk_i) begin
      if (int_rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup & ~is_mapped(paddr_i);
         if (setup & ~pwrite_i) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr_i)
         OFF_CTRL: rd_mux = {30'h0000_0000, key_ff != AFE_KEY_IDLE, soft_rst_ff};
         OFF_GCFG: rd_mux = 32'(lock_ff);
         OFF_AXCFG[0]: rd_mux = 32'(cfg_ff[0]);
         OFF_AXCFG[1]: rd_mux = 32'(cfg_ff[1]);
         OFF_STATUS: rd_mux = 32'({fault_ff, crc_err_ff, rst_flag_ff});
         OFF_COUNT: rd_mux = 32'(count_ff);
         OFF_DEFL[0]: rd_mux = 32'(defl_ff[0]);
         OFF_DEFL[1]: rd_mux = 32'(defl_ff[1]);
         OFF_DATA[0]: rd_mux = 32'(sinc_data[0]);
         OFF_DATA[1]: rd_mux = 32'(sinc_data[1]);
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Soft reset key sequence
   always_ff @(posedge mclk_i) begin
      if (int_rst) begin
         key_ff <= AFE_KEY_IDLE;
         soft_rst_ff <= 1'b0;
      end else begin
         soft_rst_ff <= 1'b0;
         if (wr_ctrl) begin
            unique case (key_ff)
               AFE_KEY_IDLE: key_ff <= (key == KEY_STEP0) ? AFE_KEY_ONE : AFE_KEY_IDLE;
               AFE_KEY_ONE: begin
                  if (key == KEY_STEP1) begin
                     key_ff <= AFE_KEY_TWO;
                  end else begin
                     key_ff <= (key == KEY_STEP0) ? AFE_KEY_ONE : AFE_KEY_IDLE;
                  end
               end
               AFE_KEY_TWO: begin
                  key_ff <= (key == KEY_STEP0) ? AFE_KEY_ONE : AFE_KEY_IDLE;
                  soft_rst_ff <= key == KEY_STEP2;
               end
               default: key_ff <= AFE_KEY_IDLE;
            endcase
         end
      end
   end

   // Init lock sets once and holds until reset
   always_ff @(posedge mclk_i) begin
      if (int_rst) begin
         lock_ff <= LOCK_RST;
      end else if (wr_en && paddr_i == OFF_GCFG && pwdata_i[LOCK_BIT]) begin
         lock_ff <= 1'b1;
      end
   end

   // Sticky status; set wins over the read clear, only read bits clear
   always_ff @(posedge mclk_i) begin
      if (int_rst) begin
         rst_flag_ff <= RST_FLAG_RST;
      end else begin
         rst_flag_ff <= ana_fail | (rst_flag_ff & ~(st_rd & prdata_ff[ST_RST_BIT]));
      end
   end

   always_ff @(posedge mclk_i) begin
      if (int_rst) begin
         crc_err_ff <= 1'b0;
      end else begin
         crc_err_ff <= (crc_ff[0] != crc_ff[1]) |
                       (crc_err_ff & ~(st_rd & prdata_ff[ST_CRC_BIT]));
      end
   end

   always_ff @(posedge mclk_i) begin
      if (int_rst) begin
         fault_ff <= 1'b0;
      end else begin
         fault_ff <= ana_fail | (fault_ff & ~(st_rd & prdata_ff[ST_FAULT_BIT]));
      end
   end

   // Oscillator monitor: prescaler, then counter
   always_ff @(posedge mclk_i) begin
      if (int_rst) begin
         prescale_ff <= {PRESCALE_W{1'b0}};
      end else if (tick) begin
         prescale_ff <= prescale_ff + 10'h001;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (int_rst) begin
         count_ff <= COUNT_RST;
      end else if (tick && (&prescale_ff)) begin
         count_ff <= count_ff + 8'h01;
      end
   end

   afe_clkgen u_clkgen (
      .mclk_i(mclk_i),
      .rst_i(int_rst),
      .tick_o(tick),
      .gated_o(gated),
      .mod_clk_o(mod_clk_o),
      .mod_rise_o(mod_rise)
   );

   assign sd_bits = {sd_y_i, sd_x_i};

   for (genvar a = 0; a < 2; a++) begin : g_axis
      // Config writes only while unlocked
      always_ff @(posedge mclk_i) begin
         if (int_rst) begin
            cfg_ff[a] <= AX_CFG_RST;
            defl_ff[a] <= DEFL_RST;
         end else if (wr_en && !lock_ff) begin
            if (paddr_i == OFF_AXCFG[a]) begin
               cfg_ff[a] <= pwdata_i[AX_CFG_W-1:0];
            end
            if (paddr_i == OFF_DEFL[a]) begin
               defl_ff[a] <= pwdata_i[DEFL_W-1:0];
            end
         end
      end

      // Core clock divider chain and its CRC
      always_ff @(posedge mclk_i) begin
         if (int_rst) begin
            div_ff[a] <= {CORE_DIV_W{1'b0}};
            crc_ff[a] <= CRC_SEED;
         end else if (tick) begin
            div_ff[a] <= div_ff[a] + 8'h01;
            crc_ff[a] <= crc_step(crc_ff[a], div_ff[a]);
         end
      end

      always_ff @(posedge mclk_i) begin
         if (int_rst) begin
            st_ff[a] <= 1'b0;
         end else begin
            st_ff[a] <= cfg_ff[a][AX_ST_BIT];
         end
      end

      afe_sinc u_sinc (
         .mclk_i(mclk_i),
         .rst_i(int_rst),
         .bit_en_i(mod_rise),
         .bit_i(sd_bits[a]),
         .dec16_i(cfg_ff[a][LPF_DEC16_BIT]),
         .data_o(sinc_data[a]),
         .valid_o(sinc_valid[a])
      );
   end

   // Outputs
   always_ff @(posedge mclk_i) begin
      if (int_rst) begin
         offset_hold_o <= 1'b0;
         dsp_clk_en_o <= 1'b0;
      end else begin
         offset_hold_o <= |st_ff;
         dsp_clk_en_o <= gated;
      end
   end

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign fault_resp_o = fault_ff;
   assign selftest_x_o = st_ff[0];
   assign selftest_y_o = st_ff[1];
   assign x_data_o = sinc_data[0];
   assign x_valid_o = sinc_valid[0];
   assign y_data_o = sinc_data[1];
   assign y_valid_o = sinc_valid[1];
endmodule : afe_front_end

// ---- test/afe_sva.sv ----
// Port level checks for the accelerometer front end
`timescale 1ns/10ps
module afe_sva
   import afe_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic vreg_uv_i,
   input wire logic vreg_ov_i,
   input wire logic vrega_uv_i,
   input wire logic vrega_ov_i,
   input wire logic vss_loss_i,
   input wire logic vssa_loss_i,
   input wire logic mod_clk_o,
   input wire logic dsp_clk_en_o,
   input wire logic x_valid_o,
   input wire logic selftest_x_o,
   input wire logic selftest_y_o,
   input wire logic offset_hold_o,
   input wire logic fault_resp_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   logic [4:0] en_cnt_ff;
   logic [4:0] per_cnt_ff;
   logic hard_any;
   logic ctrl_wr;
   // Internal resets restart the period count so no cut period is judged
   assign hard_any = vreg_uv_i | vreg_ov_i | vss_loss_i | vssa_loss_i;
   assign ctrl_wr = psel_i & penable_i & pready_o & pwrite_i & (paddr_i == OFF_CTRL);
   // Slot pulses and cycles since the last modulator rise
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || hard_any || ctrl_wr || $rose(mod_clk_o)) begin
         en_cnt_ff <= {4'h0, dsp_clk_en_o};
         per_cnt_ff <= 5'h01;
      end else begin
         en_cnt_ff <= en_cnt_ff + {4'h0, dsp_clk_en_o};
         per_cnt_ff <= per_cnt_ff + {4'h0, per_cnt_ff != 5'h1F};
      end
   end
   sequence s_key(logic [1:0] k);
      psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFF_CTRL && pwdata_i[1:0] == k;
   endsequence
   sequence s_keys;
      s_key(KEY_STEP0) ##3 s_key(KEY_STEP1) ##3 s_key(KEY_STEP2);
   endsequence
   property p_zero_wait;
      psel_i && !penable_i |=> pready_o;
   endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("no ready in access");
   property p_ready_access;
      pready_o |-> psel_i && penable_i;
   endproperty
   a_ready_access: assert property (p_ready_access) else $error("stray ready");
   property p_six_slots;
      $rose(mod_clk_o) && per_cnt_ff == 5'h19 |-> en_cnt_ff == 5'h06;
   endproperty
   a_six_slots: assert property (p_six_slots) else $error("slot count");
   property p_quiet_edge;
      $rose(mod_clk_o) |-> !dsp_clk_en_o && !$past(dsp_clk_en_o) && !$past(dsp_clk_en_o, 2) &&
         !$past(dsp_clk_en_o, 3);
   endproperty
   a_quiet_edge: assert property (p_quiet_edge) else $error("slot before edge");
   property p_valid_pulse;
      x_valid_o |=> !x_valid_o [*8];
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("valid too close");
   property p_hold;
      offset_hold_o == $past(selftest_x_o || selftest_y_o);
   endproperty
   a_hold: assert property (p_hold) else $error("offset hold");
   property p_fault;
      vrega_uv_i || vrega_ov_i |-> ##[1:3] fault_resp_o;
   endproperty
   a_fault: assert property (p_fault) else $error("no fault response");
   property p_hard;
      vreg_uv_i || vreg_ov_i || vss_loss_i || vssa_loss_i
         |-> ##[1:3] !mod_clk_o && !x_valid_o && !pready_o;
   endproperty
   a_hard: assert property (p_hard) else $error("no hard reset");
   property p_soft;
      s_keys |-> ##[1:3] !fault_resp_o && !selftest_x_o;
   endproperty
   a_soft: assert property (p_soft) else $error("no soft reset");
endmodule : afe_sva

// ---- test/afe_sd_model.sv ----
// Behavioural sigma-delta modulator pair
`timescale 1ns/10ps
module afe_sd_model (
   input wire logic mclk_i,
   input wire logic mod_clk_i,
   input wire logic [1:0] x_mode_i,
   input wire logic [1:0] y_mode_i,
   output logic sd_x_o,
   output logic sd_y_o
);
   logic mod_q_ff = 1'b0;
   logic alt_ff = 1'b0;
   initial begin
      sd_x_o = 1'b0;
      sd_y_o = 1'b0;
   end
   // Mode 2 alternates, else bit 0 is a constant level
   always @(posedge mclk_i) begin
      mod_q_ff <= mod_clk_i;
      if (mod_clk_i && !mod_q_ff) begin
         alt_ff <= !alt_ff;
         sd_x_o <= (x_mode_i == 2'h2) ? alt_ff : x_mode_i[0];
         sd_y_o <= (y_mode_i == 2'h2) ? alt_ff : y_mode_i[0];
      end
   end
endmodule : afe_sd_model

// ---- test/afe_front_end_bench.sv ----
// Self-checking bench for the accelerometer front end
`timescale 1ns/10ps
module afe_front_end_bench;
   import afe_pkg::*;
   logic mclk_i = 1'b0, sys_rst_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00, c0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, last_rd, seed = 32'h4C0C;
   logic vrega_uv_i = 1'b0, vrega_ov_i = 1'b0, sd_x_i, sd_y_i;
   logic [3:0] hard = 4'h0;
   logic [1:0] x_mode = 2'h1, y_mode = 2'h2;
   logic pready_o, pslverr_o, mod_clk_o, dsp_clk_en_o, x_valid_o, y_valid_o;
   logic selftest_x_o, selftest_y_o, offset_hold_o, fault_resp_o;
   logic [SINC_W-1:0] x_data_o, y_data_o;
   logic [7:0] dv [2];
   logic [33:0] exp_q [$];
   logic [33:0] e;
   int n_errors = 0, samples_checked = 0, cyc = 0, n;
   afe_front_end DUT (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sd_x_i, .sd_y_i, .vreg_uv_i(hard[0]),
      .vreg_ov_i(hard[1]), .vrega_uv_i, .vrega_ov_i, .vss_loss_i(hard[2]),
      .vssa_loss_i(hard[3]), .mod_clk_o, .dsp_clk_en_o, .x_data_o, .x_valid_o, .y_data_o,
      .y_valid_o, .selftest_x_o, .selftest_y_o, .offset_hold_o, .fault_resp_o);
   afe_sd_model u_mod (.mclk_i, .mod_clk_i(mod_clk_o), .x_mode_i(x_mode),
      .y_mode_i(y_mode), .sd_x_o(sd_x_i), .sd_y_o(sd_y_i));
   initial begin
      forever #20 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         n_errors++;
         $display("unexpected at %0t seen %h expected %h", $time, s, x);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [33:0] x);
      exp_q.push_back(x);
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge mclk_i);
      end while (pready_o !== 1'b1);
      last_rd = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 34'h0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, {2'b10, x});
   endtask : rd
   task automatic gap(input logic y, output int c);
      c = 0;
      for (int k = 0; k < 2; k++) begin
         c = 0;
         do begin
            @(posedge mclk_i);
            c++;
         end while ((y ? y_valid_o : x_valid_o) !== 1'b1 && c < 1000);
      end
   endtask : gap
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         end_sim();
      end
   end
   // Answer checker, one note per completed transfer
   always @(posedge mclk_i) begin
      if (psel_i && penable_i && pready_o === 1'b1) begin
         e = exp_q.pop_front();
         check({31'h0, pslverr_o}, {31'h0, e[32]});
         if (e[33]) check(prdata_o, e[31:0]);
      end
   end
   initial begin
      repeat (12) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      rd(OFF_STATUS, 32'h1);
      rd(OFF_STATUS, 32'h0);
      apb(1'b0, 8'h3C, 32'h0, {2'b11, 32'h0});
      apb(1'b1, 8'h3C, 32'hFFFF, 34'h100000000);
      for (int i = 0; i < 2; i++) begin
         seed = xs(seed);
         dv[i] = seed[7:0];
         wr(OFF_DEFL[i], seed);
         rd(OFF_DEFL[i], {24'h0, dv[i]});
      end
      apb(1'b0, OFF_COUNT, 32'h0, 34'h0);
      c0 = last_rd[7:0];
      repeat (6397) @(posedge mclk_i);
      apb(1'b0, OFF_COUNT, 32'h0, 34'h0);
      check({24'h0, last_rd[7:0] - c0}, 32'h2);
      $display("test registers done");
      repeat (6) gap(1'b0, n);
      check(32'(n), 32'hC8);
      check({18'h0, x_data_o}, 32'h1000);
      rd(OFF_DATA[1], 32'h800);
      check({18'h0, y_data_o}, 32'h800);
      wr(OFF_AXCFG[0], 32'h8);
      repeat (3) gap(1'b0, n);
      check(32'(n), 32'h190);
      gap(1'b1, n);
      check(32'(n), 32'hC8);
      rd(OFF_DATA[0], 32'h1000);
      $display("test stream done");
      wr(OFF_AXCFG[1], 32'h10);
      repeat (3) @(posedge mclk_i);
      check({30'h0, selftest_y_o, offset_hold_o}, 32'h3);
      wr(OFF_AXCFG[1], 32'h0);
      repeat (3) @(posedge mclk_i);
      check({30'h0, selftest_y_o, offset_hold_o}, 32'h0);
      wr(OFF_GCFG, 32'h1);
      wr(OFF_AXCFG[0], 32'h10);
      wr(OFF_DEFL[0], ~seed);
      rd(OFF_DEFL[0], {24'h0, dv[0]});
      gap(1'b0, n);
      check({31'h0, selftest_x_o}, 32'h0);
      check(32'(n), 32'h190);
      $display("test self test done");
      for (int i = 0; i < 2; i++) begin
         {vrega_ov_i, vrega_uv_i} <= 2'(i + 1);
         repeat (2) @(posedge mclk_i);
         {vrega_ov_i, vrega_uv_i} <= 2'h0;
         repeat (3) @(posedge mclk_i);
         check({31'h0, fault_resp_o}, 32'h1);
         rd(OFF_STATUS, 32'h5);
         rd(OFF_STATUS, 32'h0);
      end
      wr(OFF_CTRL, 32'h3);
      wr(OFF_CTRL, 32'h2);
      wr(OFF_CTRL, 32'h1);
      rd(OFF_GCFG, 32'h1);
      vrega_uv_i <= 1'b1;
      @(posedge mclk_i);
      vrega_uv_i <= 1'b0;
      wr(OFF_CTRL, {30'h0, KEY_STEP0});
      wr(OFF_CTRL, {30'h0, KEY_STEP1});
      wr(OFF_CTRL, {30'h0, KEY_STEP2});
      repeat (4) @(posedge mclk_i);
      check({31'h0, fault_resp_o}, 32'h0);
      rd(OFF_GCFG, 32'h0);
      rd(OFF_STATUS, 32'h1);
      $display("test faults done");
      for (int i = 0; i < 4; i++) begin
         wr(OFF_GCFG, 32'h1);
         hard <= 4'(1 << i);
         repeat (3) @(posedge mclk_i);
         check({30'h0, mod_clk_o, x_valid_o}, 32'h0);
         hard <= 4'h0;
         repeat (2) @(posedge mclk_i);
         rd(OFF_GCFG, 32'h0);
         rd(OFF_STATUS, 32'h1);
      end
      $display("test hard reset done");
      end_sim();
   end
endmodule : afe_front_end_bench
bind afe_front_end afe_sva u_sva (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .pready_o, .vreg_uv_i, .vreg_ov_i, .vrega_uv_i, .vrega_ov_i,
   .vss_loss_i, .vssa_loss_i, .mod_clk_o, .dsp_clk_en_o, .x_valid_o, .selftest_x_o,
   .selftest_y_o, .offset_hold_o, .fault_resp_o);
